// *** logic/dpt_pkg.sv ***
// Constants, codes and state types shared by the drive protection logic.
// Assumes a single 100 MHz control clock; setting times count in 0.1 s steps.
package dpt_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_TIME_MS = 100;
   localparam int TICK_CYCLES = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PRE_W = 24;
   localparam int TIME_W = 13;
   localparam logic [12:0] DECEL_MAX = 13'h1770;

   // ==========================================================
   // Terminal function codes and modes
   localparam logic [3:0] FN_OUTPUT_BLOCK = 4'h5;
   localparam logic [3:0] FN_FAN_WARN = 4'h8;
   localparam logic [3:0] FN_LOW_VOLT = 4'hB;
   localparam logic FAN_MODE_TRIP = 1'b0;
   localparam logic FAN_MODE_WARN = 1'b1;
   localparam int N_TERM = 8;
   localparam int N_RELAY = 2;
   localparam int DATA_W = 16;

   // ==========================================================
   // Synchroniser bit positions
   localparam int SY_FAN = 0;
   localparam int SY_DCLOW = 1;
   localparam int SY_HOT = 2;
   localparam int SY_RUN = 3;
   localparam int SY_RST = 4;
   localparam int SY_TERM = 5;
   localparam int SY_W = 13;

   // ==========================================================
   // Drive operating states
   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_BLOCKED, ST_TRIP} dpt_mode_e;
endpackage

// *** logic/dpt_timer_if.sv ***
// Control and status of one 0.1 s step countdown timer.
// Assumes controller and timer share the control clock.
`timescale 1ns/1ps
interface dpt_timer_if #(parameter int W = 13);
   logic start;
   logic cancel;
   logic [W-1:0] load;
   logic busy;
   logic done;
   logic [W-1:0] remaining;
   modport ctl (output start, output cancel, output load,
                input busy, input done, input remaining);
   modport tmr (input start, input cancel, input load,
                output busy, output done, output remaining);
endinterface

// *** logic/dpt_timer.sv ***
// Countdown timer in 0.1 s steps with a cycle prescaler.
// Assumes start and cancel are single-cycle requests on the control clock.
`timescale 1ns/1ps
module dpt_timer #(
   parameter int TICK_CYCLES = dpt_pkg::TICK_CYCLES,
   parameter int W = dpt_pkg::TIME_W
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Timer control
   dpt_timer_if.tmr t
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [W-1:0] rem;
      logic [dpt_pkg::PRE_W-1:0] pre;
   } dpt_tmr_s;

   localparam logic [dpt_pkg::PRE_W-1:0] PRE_LAST = dpt_pkg::PRE_W'(TICK_CYCLES - 1);

   dpt_tmr_s r;
   dpt_tmr_s next_r;

   // ==========================================================
   // Next state: load, count steps, pulse done at zero
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      if (t.cancel) begin
         next_r.busy = 1'b0;
      end else if (t.start) begin
         next_r.busy = (t.load != '0);
         next_r.done = (t.load == '0);
         next_r.rem = t.load;
         next_r.pre = '0;
      end else if (r.busy) begin
         if (r.pre == PRE_LAST) begin
            next_r.pre = '0;
            next_r.rem = r.rem - W'(1);
            if (r.rem == W'(1)) begin
               next_r.busy = 1'b0;
               next_r.done = 1'b1;
            end
         end else begin
            next_r.pre = r.pre + dpt_pkg::PRE_W'(1);
         end
      end
   end

   // State register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign t.busy = r.busy;
   assign t.done = r.done;
   assign t.remaining = r.rem;
endmodule

// *** logic/dpt_trip_logic.sv ***
// Fan fault, DC-link low voltage and output-block protection for a motor drive.
// Assumes fault sense, terminals and commands arrive from pins; settings and
// live frequency/current come from logic on the control clock.
// Functional notes
// R1: Fan fault in trip mode blocks output, trips.
// R2: Fan fault in warn mode drives code 8.
// R3: Overheat blocks output even during fan warning.
// R4: DC-link low voltage blocks output, trips; the code starts the trip delay only in ST_RUN or ST_DECEL.
// R5: Block at once; trip after programmed delay.
// R6: Code 11 outputs follow low voltage undelayed.
// R7: Block terminal code 5 stops output, indicates.
// R8: Hold frequency and current while blocked.
// R9: Resume needs block released, new run.
// R10: Zero decel time means immediate free-run.
// R11: Nonzero decel time ramps down over time.
// R12: Controller picks decel time avoiding overvoltage; the code uses block_decel_time_i clamped to DECEL_MAX instead.
// R13: Faults synchronised; trips latch until reset.
`timescale 1ns/1ps
module dpt_trip_logic #(
   parameter int TICK_CYCLES = dpt_pkg::TICK_CYCLES
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Fault sense and command pins
   input wire logic fan_fault_i,
   input wire logic dc_low_i,
   input wire logic over_temp_i,
   input wire logic run_cmd_i,
   input wire logic trip_reset_i,
   input wire logic [dpt_pkg::N_TERM-1:0] terminal_i,
   // Settings
   input wire logic fan_trip_mode_i,
   input wire logic [dpt_pkg::TIME_W-1:0] undervoltage_trip_delay_i,
   input wire logic [dpt_pkg::TIME_W-1:0] block_decel_time_i,
   input wire logic [dpt_pkg::N_TERM-1:0][3:0] input_terminal_function_i,
   input wire logic [dpt_pkg::N_RELAY-1:0][3:0] relay_output_function_i,
   input wire logic [3:0] open_collector_function_i,
   // Live operating values
   input wire logic [dpt_pkg::DATA_W-1:0] freq_i,
   input wire logic [dpt_pkg::DATA_W-1:0] current_i,
   // Power stage and indication
   output logic gate_enable_o,
   output logic fan_trip_o,
   output logic overheat_trip_o,
   output logic uv_trip_o,
   output logic block_ind_o,
   output logic decel_active_o,
   output logic [dpt_pkg::TIME_W-1:0] decel_left_o,
   output logic [dpt_pkg::DATA_W-1:0] freq_hold_o,
   output logic [dpt_pkg::DATA_W-1:0] current_hold_o,
   // Relay and open-collector outputs
   output logic [dpt_pkg::N_RELAY-1:0] relay_o,
   output logic open_collector_o
);
   typedef struct packed {
      logic [dpt_pkg::SY_W-1:0] s1;
      logic [dpt_pkg::SY_W-1:0] s2;
      logic run_prev;
      dpt_pkg::dpt_mode_e mode;
      logic fan_trip;
      logic heat_trip;
      logic uv_trip;
      logic uv_pend;
      logic [dpt_pkg::DATA_W-1:0] freq_hold;
      logic [dpt_pkg::DATA_W-1:0] cur_hold;
      logic [dpt_pkg::N_RELAY-1:0] relay;
      logic oc;
      logic gate;
      logic block_ind;
   } dpt_top_s;

   dpt_top_s r;
   dpt_top_s next_r;

   dpt_timer_if #(.W(dpt_pkg::TIME_W)) uvt ();
   dpt_timer_if #(.W(dpt_pkg::TIME_W)) dct ();

   // ==========================================================
   // Decoding helpers
   function automatic logic fn_is(input logic [3:0] code, input logic [3:0] want);
      fn_is = (code == want);
   endfunction

   function automatic logic out_sel(input logic [3:0] code, input logic fan_w,
                                    input logic lv_w);
      out_sel = (fn_is(code, dpt_pkg::FN_FAN_WARN) & fan_w) |
                (fn_is(code, dpt_pkg::FN_LOW_VOLT) & lv_w);
   endfunction

   // Synchronised inputs, second stage only
   logic fan;
   logic dc;
   logic hot;
   logic run;
   logic clr;
   logic [dpt_pkg::N_TERM-1:0] blk_hit;
   logic blk;
   logic fan_w;
   logic [dpt_pkg::N_RELAY-1:0] relay_val;
   assign fan = r.s2[dpt_pkg::SY_FAN];
   assign dc = r.s2[dpt_pkg::SY_DCLOW];
   assign hot = r.s2[dpt_pkg::SY_HOT];
   assign run = r.s2[dpt_pkg::SY_RUN];
   assign clr = r.s2[dpt_pkg::SY_RST];
   assign fan_w = fan & (fan_trip_mode_i == dpt_pkg::FAN_MODE_WARN);

   // Block terminal decode and alarm output selection
   genvar gi;
   generate
      for (gi = 0; gi < dpt_pkg::N_TERM; gi++) begin : g_term
         assign blk_hit[gi] = r.s2[dpt_pkg::SY_TERM + gi] &
                              fn_is(input_terminal_function_i[gi], dpt_pkg::FN_OUTPUT_BLOCK); // R7
      end
      for (gi = 0; gi < dpt_pkg::N_RELAY; gi++) begin : g_relay
         assign relay_val[gi] = out_sel(relay_output_function_i[gi], fan_w, dc); // R2 R6
      end
   endgenerate
   assign blk = |blk_hit;

   // Latched trips, set wins over reset
   logic next_fan_trip;
   logic next_heat_trip;
   logic next_uv_trip;
   logic trip_any;
   assign next_fan_trip = (r.fan_trip & ~clr) |
                          (fan & (fan_trip_mode_i == dpt_pkg::FAN_MODE_TRIP)); // R1 R13
   assign next_heat_trip = (r.heat_trip & ~clr) | hot; // R3 R13
   assign next_uv_trip = (r.uv_trip & ~clr) | uvt.done; // R5 R13
   assign trip_any = next_fan_trip | next_heat_trip | next_uv_trip;

   // Timer requests
   logic running;
   logic blk_take;
   logic [dpt_pkg::TIME_W-1:0] dec_t;
   assign running = (r.mode == dpt_pkg::ST_RUN) || (r.mode == dpt_pkg::ST_DECEL);
   assign dec_t = (block_decel_time_i > dpt_pkg::DECEL_MAX) ? dpt_pkg::DECEL_MAX :
                  block_decel_time_i;
   assign blk_take = (r.mode == dpt_pkg::ST_RUN) & blk & ~trip_any;
   assign uvt.start = running & dc & ~r.uv_pend & ~r.uv_trip; // R4 R5
   assign uvt.cancel = r.uv_pend & ~dc;
   assign uvt.load = undervoltage_trip_delay_i;
   assign dct.start = blk_take & (dec_t != '0); // R11
   assign dct.cancel = (r.mode == dpt_pkg::ST_DECEL) & trip_any;
   assign dct.load = dec_t;

   // ==========================================================
   // Next state of the whole block
   always_comb begin
      next_r = r;
      next_r.s1 = {terminal_i, trip_reset_i, run_cmd_i, over_temp_i, dc_low_i, fan_fault_i}; // R13
      next_r.s2 = r.s1;
      next_r.run_prev = run;
      next_r.fan_trip = next_fan_trip;
      next_r.heat_trip = next_heat_trip;
      next_r.uv_trip = next_uv_trip;
      if (uvt.start) begin
         next_r.uv_pend = 1'b1;
      end else if (uvt.done || uvt.cancel) begin
         next_r.uv_pend = 1'b0;
      end
      case (r.mode)
         dpt_pkg::ST_IDLE: begin
            if (trip_any) begin
               next_r.mode = dpt_pkg::ST_TRIP;
            end else if (run & ~r.run_prev & ~blk) begin
               next_r.mode = dpt_pkg::ST_RUN; // R9
            end
         end
         dpt_pkg::ST_RUN: begin
            if (trip_any) begin
               next_r.mode = dpt_pkg::ST_TRIP;
            end else if (blk_take) begin
               next_r.freq_hold = freq_i; // R8
               next_r.cur_hold = current_i;
               next_r.mode = (dec_t == '0) ? dpt_pkg::ST_BLOCKED : dpt_pkg::ST_DECEL; // R10 R11
            end
         end
         dpt_pkg::ST_DECEL: begin
            if (trip_any) begin
               next_r.mode = dpt_pkg::ST_TRIP;
            end else if (dct.done) begin
               next_r.mode = dpt_pkg::ST_BLOCKED;
            end
         end
         dpt_pkg::ST_BLOCKED: begin
            if (trip_any) begin
               next_r.mode = dpt_pkg::ST_TRIP;
            end else if (~blk) begin
               next_r.mode = dpt_pkg::ST_IDLE; // R9
            end
         end
         dpt_pkg::ST_TRIP: begin
            if (~trip_any) begin
               next_r.mode = dpt_pkg::ST_IDLE;
            end
         end
         default: begin
            next_r.mode = dpt_pkg::ST_IDLE;
         end
      endcase
      // Output enable drops on any trip or low DC link, and on a block once any deceleration ends
      next_r.gate = ((next_r.mode == dpt_pkg::ST_RUN) || (next_r.mode == dpt_pkg::ST_DECEL)) &
                    ~dc; // R1 R3 R4 R5 R7
      next_r.block_ind = (next_r.mode == dpt_pkg::ST_DECEL) ||
                         (next_r.mode == dpt_pkg::ST_BLOCKED); // R7
      next_r.relay = relay_val;
      next_r.oc = out_sel(open_collector_function_i, fan_w, dc); // R2 R6
   end

   // State register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Timers for the low-voltage delay and the block deceleration
   dpt_timer #(.TICK_CYCLES(TICK_CYCLES), .W(dpt_pkg::TIME_W)) u_uv_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .t(uvt)
   );

   dpt_timer #(.TICK_CYCLES(TICK_CYCLES), .W(dpt_pkg::TIME_W)) u_dc_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .t(dct)
   );

   // Outputs
   assign gate_enable_o = r.gate;
   assign fan_trip_o = r.fan_trip;
   assign overheat_trip_o = r.heat_trip;
   assign uv_trip_o = r.uv_trip;
   assign block_ind_o = r.block_ind;
   assign decel_active_o = (r.mode == dpt_pkg::ST_DECEL);
   assign decel_left_o = dct.remaining;
   assign freq_hold_o = r.freq_hold;
   assign current_hold_o = r.cur_hold;
   assign relay_o = r.relay;
   assign open_collector_o = r.oc;

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_fan_trip_gate: assert property (fan_trip_o |-> !gate_enable_o) // R1
      else $error("gate on during fan trip");
   a_fan_trip_set: assert property ((fan && fan_trip_mode_i == dpt_pkg::FAN_MODE_TRIP)
      |=> fan_trip_o) // R1
      else $error("fan trip not latched");
   a_fan_warn_relay: assert property ((fan_w && relay_output_function_i[0] == 4'h8)
      |=> relay_o[0] && !($past(fan_trip_o) ^ fan_trip_o && fan_trip_o)) // R2
      else $error("fan warning missing or tripped");
   a_heat_block: assert property (hot |=> !gate_enable_o && overheat_trip_o) // R3
      else $error("overheat did not block output");
   a_uv_block: assert property (dc |=> !gate_enable_o) // R4
      else $error("low DC link did not block output");
   a_uv_zero_delay: assert property ((uvt.start && undervoltage_trip_delay_i == 13'h0000)
      |-> ##2 uv_trip_o) // R5
      else $error("zero delay low voltage trip late");
   a_uv_wait: assert property ((r.uv_pend && !uvt.done && !uv_trip_o) |=> !uv_trip_o) // R5
      else $error("low voltage trip before delay");
   a_lv_relay: assert property ((dc && relay_output_function_i[1] == 4'hB) |=> relay_o[1]) // R6
      else $error("low voltage alarm missing");
   a_block_free: assert property ((blk_take && dec_t == 13'h0000)
      |=> !gate_enable_o && block_ind_o && !decel_active_o) // R7 R10
      else $error("free-run block wrong");
   a_hold_stable: assert property ((block_ind_o && $past(block_ind_o)) |-> $stable(freq_hold_o)
      && $stable(current_hold_o)) // R8
      else $error("held values changed");
   a_no_resume: assert property ((r.mode == dpt_pkg::ST_BLOCKED && blk)
      |=> r.mode != dpt_pkg::ST_RUN) // R9
      else $error("resumed with block asserted");
   a_decel_start: assert property ((blk_take && dec_t != 13'h0000 && !dc)
      |=> decel_active_o && gate_enable_o && decel_left_o == $past(dec_t)) // R11
      else $error("deceleration not started");
   a_trip_hold: assert property ((uv_trip_o && !clr) |=> uv_trip_o) // R13
      else $error("trip released without reset");

   c_decel_done: cover property (decel_active_o ##1 !decel_active_o && block_ind_o);
   c_uv_trip: cover property ($rose(uv_trip_o));
   c_fan_warn: cover property (fan_w && relay_o[0]);
   c_resume: cover property (r.mode == dpt_pkg::ST_IDLE && block_ind_o == 1'b0 ##1
      r.mode == dpt_pkg::ST_RUN);
endmodule

// *** verification/dpt_stage_model.sv ***
// Power stage model: live frequency and current seen by the trip logic.
// Assumes the trip logic gate enable and one shared control clock.
`timescale 1ns/1ps
module dpt_stage_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Gate and speed set point
   input wire logic gate_enable_i,
   input wire logic [15:0] target_i,
   // Live values
   output logic [15:0] freq_o,
   output logic [15:0] current_o
);
   // ==========================================================
   // Driven: track set point; coasting: frequency falls, current toggles
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         freq_o <= 16'h0000;
         current_o <= 16'h0000;
      end else if (gate_enable_i) begin
         freq_o <= target_i;
         current_o <= ~target_i;
      end else begin
         freq_o <= freq_o - 16'h0001;
         current_o <= ~current_o;
      end
   end
endmodule

// *** verification/dpt_trip_logic_tb.sv ***
// Self-checking bench for the drive protection trip logic.
// Assumes a shortened prescaler so 0.1 s steps last a few cycles.
`timescale 1ns/1ps
module dpt_trip_logic_tb;
   localparam int TK = 4;
   logic mclk_i, rst_i, fan_fault_i, dc_low_i, over_temp_i, run_cmd_i, trip_reset_i;
   logic fan_mode, gate, fan_trip, oh_trip, uv_trip, blk, dec_act, oc;
   logic [7:0] terminal_i;
   logic [12:0] uv_delay, decel, decel_left;
   logic [7:0][3:0] term_fn;
   logic [1:0][3:0] relay_fn;
   logic [3:0] oc_fn;
   logic [1:0] relay;
   logic [15:0] freq, current, target, freq_hold, current_hold;
   logic [12:0] dly[2];
   logic [8:0] exp_q[$];
   int bad_count, cmp_count, seed;
   event look;
   wire [8:0] outs = {gate, fan_trip, oh_trip, uv_trip, blk, dec_act, relay, oc};

   // ==========================================================
   // Clock, design and power stage
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   dpt_trip_logic #(.TICK_CYCLES(TK)) uut (.mclk_i(mclk_i), .rst_i(rst_i),
      .fan_fault_i(fan_fault_i), .dc_low_i(dc_low_i), .over_temp_i(over_temp_i),
      .run_cmd_i(run_cmd_i), .trip_reset_i(trip_reset_i), .terminal_i(terminal_i),
      .fan_trip_mode_i(fan_mode), .undervoltage_trip_delay_i(uv_delay),
      .block_decel_time_i(decel), .input_terminal_function_i(term_fn),
      .relay_output_function_i(relay_fn), .open_collector_function_i(oc_fn),
      .freq_i(freq), .current_i(current), .gate_enable_o(gate),
      .fan_trip_o(fan_trip), .overheat_trip_o(oh_trip), .uv_trip_o(uv_trip),
      .block_ind_o(blk), .decel_active_o(dec_act), .decel_left_o(decel_left),
      .freq_hold_o(freq_hold), .current_hold_o(current_hold), .relay_o(relay),
      .open_collector_o(oc));
   dpt_stage_model stage (.mclk_i(mclk_i), .rst_i(rst_i), .gate_enable_i(gate),
      .target_i(target), .freq_o(freq), .current_o(current));

   // ==========================================================
   // Shared tasks
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Queue an expected output pattern and ask the watcher to compare
   task automatic note(input logic [8:0] e);
      @(negedge mclk_i);
      exp_q.push_back(e);
      -> look;
      @(posedge mclk_i);
   endtask
   task automatic start_run();
      run_cmd_i <= 1'b0;
      tick(4);
      run_cmd_i <= 1'b1;
      tick(6);
   endtask
   task automatic clear_trips();
      trip_reset_i <= 1'b1;
      tick(6);
      trip_reset_i <= 1'b0;
      tick(6);
   endtask
   task automatic close_out();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Watcher: oldest note against the settled outputs
   always @(look) begin
      check("outputs", {7'h00, outs}, {7'h00, exp_q.pop_front()});
   end

   // Hang guard
   initial begin
      tick(20000);
      bad_count++;
      close_out();
   end

   // ==========================================================
   // Main sequence
   initial begin
      seed = 32'h8364;
      bad_count = 0;
      cmp_count = 0;
      rst_i = 1'b1;
      {fan_fault_i, dc_low_i, over_temp_i, run_cmd_i, trip_reset_i, fan_mode} = 6'h00;
      terminal_i = 8'h00;
      uv_delay = 13'h0000;
      decel = 13'h0000;
      term_fn = {8{4'h3}};
      term_fn[2] = dpt_pkg::FN_OUTPUT_BLOCK;
      relay_fn[0] = dpt_pkg::FN_FAN_WARN;
      relay_fn[1] = dpt_pkg::FN_LOW_VOLT;
      oc_fn = dpt_pkg::FN_LOW_VOLT;
      target = 16'($random(seed));
      dly[0] = 13'h0000;
      dly[1] = 13'h0003;
      tick(8);
      rst_i <= 1'b0;
      note(9'h000);
      // Free-run block, captured values, refused run, resume
      start_run();
      note(9'h100);
      terminal_i[2] <= 1'b1;
      tick(6);
      note(9'h010);
      check("freq_hold", freq_hold, target);
      check("current_hold", current_hold, ~target);
      start_run();
      note(9'h010);
      terminal_i[2] <= 1'b0;
      tick(6);
      note(9'h000);
      start_run();
      note(9'h100);
      // Timed deceleration, short enough for the load
      decel <= 13'h0003;
      terminal_i[2] <= 1'b1;
      tick(5);
      note(9'h118);
      check("decel_left", {3'h0, decel_left}, 16'h0003);
      tick(25);
      note(9'h010);
      terminal_i[2] <= 1'b0;
      decel <= 13'h0000;
      // Low voltage with no delay and with a delay
      foreach (dly[i]) begin
         start_run();
         uv_delay <= dly[i];
         dc_low_i <= 1'b1;
         tick(5);
         note(dly[i] == 13'h0000 ? 9'h025 : 9'h005);
         tick(25);
         note(9'h025);
         dc_low_i <= 1'b0;
         tick(6);
         note(9'h020);
         clear_trips();
         note(9'h000);
      end
      // Fan warning, then overheat while warning
      start_run();
      fan_mode <= dpt_pkg::FAN_MODE_WARN;
      fan_fault_i <= 1'b1;
      tick(5);
      note(9'h102);
      over_temp_i <= 1'b1;
      tick(5);
      note(9'h042);
      over_temp_i <= 1'b0;
      fan_fault_i <= 1'b0;
      clear_trips();
      note(9'h000);
      // Fan trip mode, latched after the fault goes away
      start_run();
      fan_mode <= dpt_pkg::FAN_MODE_TRIP;
      fan_fault_i <= 1'b1;
      tick(5);
      note(9'h080);
      fan_fault_i <= 1'b0;
      tick(5);
      note(9'h080);
      clear_trips();
      note(9'h000);
      // Oversized deceleration time is clamped, then reset lands in mid-deceleration
      start_run();
      decel <= 13'h1FFF;
      terminal_i[2] <= 1'b1;
      tick(5);
      check("decel_clamp", {3'h0, decel_left}, 16'(dpt_pkg::DECEL_MAX));
      note(9'h118);
      rst_i <= 1'b1;
      tick(2);
      rst_i <= 1'b0;
      note(9'h000);
      close_out();
   end
endmodule
